// ==== logic/dacm_chan_if.sv ====
// Per-channel signals between the mapper and its two stage modules
`timescale 1ns/1ps
`default_nettype none
interface dacm_chan_if;
	logic [15:0] word;
	logic signed [7:0] offset;
	logic [2:0] range;
	logic signed [15:0] code;
	logic sat;
	logic [15:0] level;

	// Driver of word, offset and range
	modport top (output word, output offset, output range, input level, input sat);
	// Offset add and saturation stage
	modport limit (input word, input offset, input range, output code, output sat);
	// Range to converter code stage
	modport scale (input code, input range, output level);
endinterface
`default_nettype wire

// ==== logic/dacm_limit.sv ====
// Offset calibration add and range saturation for one channel
`timescale 1ns/1ps
`default_nettype none
module dacm_limit
(
	// Channel carrier
	dacm_chan_if.limit bus
);
	logic signed [16:0] sum;
	logic signed [16:0] lo;
	logic signed [16:0] hi;

	// Calibrated sum of word and offset, sign extended
	always_comb
	begin
		sum = 17'(signed'(bus.word)) + 17'(bus.offset);
	end

	// Valid span of the selected range
	always_comb
	begin
		case (bus.range)
			dacm_pkg::DACM_RANGE_BI_10V:
			begin
				lo = dacm_pkg::DACM_BI10_MIN;
				hi = dacm_pkg::DACM_BI10_MAX;
			end
			dacm_pkg::DACM_RANGE_BI_5V:
			begin
				lo = dacm_pkg::DACM_BI5_MIN;
				hi = dacm_pkg::DACM_BI5_MAX;
			end
			dacm_pkg::DACM_RANGE_0_10V:
			begin
				lo = dacm_pkg::DACM_ZERO_MIN;
				hi = dacm_pkg::DACM_UNI10_MAX;
			end
			dacm_pkg::DACM_RANGE_1_5V:
			begin
				lo = dacm_pkg::DACM_OFSZ_MIN;
				hi = dacm_pkg::DACM_OFSZ_MAX;
			end
			default:
			begin
				// Unlisted codes fall back to the factory 0-5 V range
				lo = dacm_pkg::DACM_ZERO_MIN;
				hi = dacm_pkg::DACM_UNI5_MAX;
			end
		endcase
	end

	// Saturate to the nearest limit
	always_comb
	begin
		if (sum > hi)
		begin
			bus.code = hi[15:0];
			bus.sat = 1'b1;
		end
		else if (sum < lo)
		begin
			bus.code = lo[15:0];
			bus.sat = 1'b1;
		end
		else
		begin
			bus.code = sum[15:0];
			bus.sat = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== logic/dacm_pkg.sv ====
// Shared constants and types of the four-channel converter code mapper
package dacm_pkg;

	// Channel count and widths
	localparam int DACM_CHANNELS = 4;
	localparam int DACM_WORD_W = 16;
	localparam int DACM_OFFS_W = 8;
	localparam int DACM_TYPE_W = 3;
	localparam int DACM_SUM_W = 17;

	// Output range selection codes
	typedef enum logic [2:0] {
		DACM_RANGE_0_5V = 3'h0,
		DACM_RANGE_0_10V = 3'h1,
		DACM_RANGE_1_5V = 3'h2,
		DACM_RANGE_BI_5V = 3'h4,
		DACM_RANGE_BI_10V = 3'h5
	} dacm_range_type;

	// Valid code spans per range
	localparam logic signed [16:0] DACM_BI10_MAX = 17'sh07F80;
	localparam logic signed [16:0] DACM_BI10_MIN = -17'sh07F80;
	localparam logic signed [16:0] DACM_BI5_MAX = 17'sh03FFF;
	localparam logic signed [16:0] DACM_BI5_MIN = -17'sh04000;
	localparam logic signed [16:0] DACM_UNI10_MAX = 17'sh07F80;
	localparam logic signed [16:0] DACM_UNI5_MAX = 17'sh03FFF;
	localparam logic signed [16:0] DACM_ZERO_MIN = 17'sh00000;
	localparam logic signed [16:0] DACM_OFSZ_MAX = 17'sh0337F;
	localparam logic signed [16:0] DACM_OFSZ_MIN = -17'sh00C80;

	// Live zero of the offset-zero ranges, in counts (1 V or 4 mA)
	localparam logic signed [15:0] DACM_LIVE_ZERO = 16'sh0C80;

	// Converter takes offset binary: sign bit flipped
	localparam logic [15:0] DACM_OFFSET_BINARY = 16'h8000;

	// Reset values
	localparam logic [15:0] DACM_WORD_RESET = 16'h0000;
	localparam logic [15:0] DACM_DAC_RESET = 16'h8000;

endpackage

// ==== logic/dacm_scale.sv ====
// Maps a saturated code to the converter's offset-binary code
`timescale 1ns/1ps
`default_nettype none
module dacm_scale
(
	// Channel carrier
	dacm_chan_if.scale bus
);
	logic signed [15:0] steps;

	// Steps of 0.3125 mV or 1.25 uA above true zero output
	always_comb
	begin
		if (bus.range == dacm_pkg::DACM_RANGE_1_5V)
			steps = bus.code + dacm_pkg::DACM_LIVE_ZERO;
		else
			steps = bus.code;
	end

	// Flip the sign bit for the offset-binary converter
	always_comb
	begin
		bus.level = steps ^ dacm_pkg::DACM_OFFSET_BINARY;
	end
endmodule
`default_nettype wire

// ==== logic/dacm_top.sv ====
// Four-channel converter code mapper: host words to converter codes
`timescale 1ns/1ps
`default_nettype none
module dacm_top
#(
	parameter int CHANNELS = dacm_pkg::DACM_CHANNELS
)
(
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Host output word writes
	input wire logic host_output_word_valid,
	input wire logic [1:0] host_output_word_index,
	input wire logic [15:0] host_output_word_data,
	// End of the host batch I/O transfer
	input wire logic host_batch_done,
	// Per-channel settings, channel 1 in the low bits
	input wire logic [CHANNELS*3-1:0] range_type,
	input wire logic [CHANNELS*8-1:0] offset_cal,
	// Converter side
	output logic [CHANNELS*16-1:0] dac_code,
	output logic dac_load,
	output logic [CHANNELS-1:0] dac_saturated
);

	// Words received during the batch, not yet applied
	logic [15:0] staging [CHANNELS];
	logic [15:0] next_staging [CHANNELS];
	// Words of the last completed batch
	logic [15:0] active [CHANNELS];
	logic [15:0] next_active [CHANNELS];
	// Pending load pulse
	logic applied;
	logic next_applied;
	// Registered converter side
	logic [CHANNELS*16-1:0] next_dac_code;
	logic next_dac_load;
	logic [CHANNELS-1:0] next_dac_saturated;
	// Per-channel stage results
	logic [15:0] level [CHANNELS];
	logic [CHANNELS-1:0] sat;

	// Stage host writes and apply them at the end of the batch
	always_comb
	begin
		next_applied = 1'b0;
		for (int i = 0; i < CHANNELS; i++)
		begin
			next_staging[i] = staging[i];
			next_active[i] = active[i];
		end
		if (host_output_word_valid)
			next_staging[host_output_word_index] = host_output_word_data;
		if (host_batch_done)
		begin
			// A write in the same cycle joins this batch
			for (int i = 0; i < CHANNELS; i++)
				next_active[i] = next_staging[i];
			next_applied = 1'b1;
		end
	end

	// Word registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				staging[i] <= dacm_pkg::DACM_WORD_RESET;
				active[i] <= dacm_pkg::DACM_WORD_RESET;
			end
			applied <= 1'b0;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				staging[i] <= next_staging[i];
				active[i] <= next_active[i];
			end
			applied <= next_applied;
		end
	end

	// One limit and one scale stage per channel
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : chan
			dacm_chan_if ch ();

			// Each channel's own word and settings
			assign ch.word = active[g];
			assign ch.offset = offset_cal[g*8 +: 8];
			assign ch.range = range_type[g*3 +: 3];
			assign level[g] = ch.level;
			assign sat[g] = ch.sat;

			dacm_limit u_limit
			(
				.bus(ch)
			);

			dacm_scale u_scale
			(
				.bus(ch)
			);
		end
	endgenerate

	// Converter outputs follow the active words and current settings
	always_comb
	begin
		for (int i = 0; i < CHANNELS; i++)
			next_dac_code[i*16 +: 16] = level[i];
		next_dac_load = applied;
		next_dac_saturated = sat;
	end

	// Output registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dac_code <= {CHANNELS{dacm_pkg::DACM_DAC_RESET}};
			dac_load <= 1'b0;
			dac_saturated <= '0;
		end
		else if (clk_en)
		begin
			dac_code <= next_dac_code;
			dac_load <= next_dac_load;
			dac_saturated <= next_dac_saturated;
		end
	end

endmodule
`default_nettype wire

// ==== logic/dacm_unused_placeholder_none.sv ====
// Intentionally minimal: shared helper types are in dacm_pkg
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/dacm_asserts.sv ====
// Port checks of the converter code mapper, bound to its top
`timescale 1ns/1ps
`default_nettype none
module dacm_asserts
#(
	parameter int CHANNELS = 4
)
(
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Host side
	input wire logic host_batch_done,
	input wire logic [CHANNELS*3-1:0] range_type,
	// Converter side
	input wire logic [CHANNELS*16-1:0] dac_code,
	input wire logic dac_load,
	input wire logic [CHANNELS-1:0] dac_saturated
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// A clamped channel 1 code sits on one limit of its range
	property lim(r, hi, lo);
		$past(clk_en) && dac_saturated[0] && $past(range_type[2:0]) == r
			|-> dac_code[15:0] == hi || dac_code[15:0] == lo;
	endproperty

	a_load_after_batch: assert property (host_batch_done && clk_en ##1 clk_en |=> dac_load)
		else $error("no load two edges after batch end");
	a_load_has_cause: assert property (dac_load && $past(clk_en) && $past(clk_en, 2) |->
		$past(host_batch_done, 2))
		else $error("load without batch end");
	a_bi10_clamp: assert property (lim(3'h5, 16'hFF80, 16'h0080))
		else $error("bipolar 10 V clamp off limit");
	a_bi5_clamp: assert property (lim(3'h4, 16'hBFFF, 16'h4000))
		else $error("bipolar 5 V clamp off limit");
	a_uni10_clamp: assert property (lim(3'h1, 16'hFF80, 16'h8000))
		else $error("unipolar 10 V clamp off limit");
	a_uni5_clamp: assert property (lim(3'h0, 16'hBFFF, 16'h8000))
		else $error("unipolar 5 V clamp off limit");
	a_live_zero_clamp: assert property (lim(3'h2, 16'hBFFF, 16'h8000))
		else $error("offset-zero clamp off limit");
	a_bi10_span: assert property ($past(clk_en) && !dac_saturated[0] &&
		$past(range_type[2:0]) == 3'h5 |-> dac_code[15:0] inside {[16'h0080:16'hFF80]})
		else $error("bipolar 10 V code outside span");

	// Main scenarios reached
	c_load: cover property (dac_load);
	c_back_to_back: cover property (dac_load ##1 dac_load);
	c_live_zero_sat: cover property (dac_saturated[0] && range_type[2:0] == 3'h2);
endmodule
bind dacm_top dacm_asserts #(.CHANNELS(CHANNELS)) dacm_asserts_inst (.clk(clk), .rstn(rstn),
	.clk_en(clk_en), .host_batch_done(host_batch_done), .range_type(range_type),
	.dac_code(dac_code), .dac_load(dac_load), .dac_saturated(dac_saturated));
`default_nettype wire

// ==== tb/dacm_host_model.sv ====
// Host controller model: writes four channel words, ending the batch with the last one
`timescale 1ns/1ps
`default_nettype none
module dacm_host_model
(
	// Clock
	input wire logic clk,
	// Word writes and batch end
	output logic valid,
	output logic [1:0] index,
	output logic [15:0] data,
	output logic done
);
	// Idle bus at time zero
	initial
	begin
		valid = 1'b0;
		index = 2'h0;
		data = 16'h0000;
		done = 1'b0;
	end

	// Channel 4 first; batch end rides with the last word; gap slows the host
	task automatic batch(input logic [63:0] w, input int gap);
		for (int i = 3; i >= 0; i--)
		begin
			valid <= 1'b1;
			index <= 2'(i);
			data <= w[i*16+:16];
			done <= (i == 0);
			@(posedge clk);
			if (gap > 0 && i > 0)
			begin
				valid <= 1'b0;
				data <= ~data;
				repeat (gap) @(posedge clk);
			end
		end
		valid <= 1'b0;
		done <= 1'b0;
		data <= ~data;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_four_channel_dac_code_mapper.sv ====
// Self-checking bench of the converter code mapper
`timescale 1ns/1ps
`default_nettype none
module tb_four_channel_dac_code_mapper;
	logic clk;
	logic rstn;
	logic clk_en;
	logic [11:0] range_type;
	logic [31:0] offset_cal;
	logic [63:0] dac_code;
	logic dac_load;
	logic [3:0] dac_saturated;
	logic [63:0] w;
	logic valid;
	logic [1:0] index;
	logic [15:0] data;
	logic done;
	int mismatches;
	int tests_run;
	int n;
	logic [11:0] held;
	logic [15:0] corners [10] = '{16'h7F80, 16'h8080, 16'h3FFF, 16'hC000, 16'hF380,
		16'h337F, 16'hFFFF, 16'h0000, 16'h7FFF, 16'h8000};

	dacm_top dacm_top_inst (.clk(clk), .rstn(rstn), .clk_en(clk_en),
		.host_output_word_valid(valid), .host_output_word_index(index),
		.host_output_word_data(data), .host_batch_done(done), .range_type(range_type),
		.offset_cal(offset_cal), .dac_code(dac_code), .dac_load(dac_load),
		.dac_saturated(dac_saturated));
	dacm_host_model dacm_host_model_inst (.clk(clk), .valid(valid), .index(index),
		.data(data), .done(done));

	// Clamp flag and offset-binary code expected for one channel
	function automatic logic [16:0] expect_code(input logic [15:0] wd, input logic [7:0] o,
		input logic [2:0] r);
		int v;
		int lo;
		int hi;
		logic sat;
		v = int'($signed(wd)) + int'($signed(o));
		lo = r == 3'h5 ? -32640 : r == 3'h4 ? -16384 : r == 3'h2 ? -3200 : 0;
		hi = r == 3'h5 || r == 3'h1 ? 32640 : r == 3'h2 ? 13183 : 16383;
		sat = v < lo || v > hi;
		v = v < lo ? lo : v > hi ? hi : v;
		v = r == 3'h2 ? v + 3200 : v;
		return {sat, v[15:0] ^ 16'h8000};
	endfunction

	// Compare and count
	task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// All four channels against the expected mapping under range settings r
	task chk_all(input logic [11:0] r);
		logic [16:0] e;
		for (int i = 0; i < 4; i++)
		begin
			e = expect_code(w[i*16+:16], offset_cal[i*8+:8], r[i*3+:3]);
			chk("code", e, {dac_saturated[i], dac_code[i*16+:16]});
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		end_of_test;
	end

	// Tests: first eight sweep every range code, then random settings
	initial
	begin
		rstn = 1'b0;
		clk_en = 1'b1;
		range_type = 12'h000;
		offset_cal = 32'h00000000;
		mismatches = 0;
		tests_run = 0;
		n = $urandom(32'h8308);
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// Outputs right after reset: zero words in the default range
		w = '0;
		@(negedge clk);
		chk("reset load", 17'h0, {16'h0000, dac_load});
		chk_all(range_type);
		for (int t = 0; t < 40; t++)
		begin
			@(posedge clk);
			range_type <= t < 8 ? {4{3'(t)}} : 12'($urandom);
			offset_cal <= t < 8 ? 32'h00000000 : $urandom;
			for (int i = 0; i < 4; i++)
				w[i*16+:16] = t % 2 ? 16'($urandom) : corners[$urandom % 10];
			dacm_host_model_inst.batch(w, t % 3);
			n = 0;
			@(negedge clk);
			while (dac_load !== 1'b1 && n < 20)
			begin
				@(negedge clk);
				n++;
			end
			chk("load", 17'h1, {16'h0000, dac_load});
			chk_all(range_type);
			// Clock enable low: a new range must not reach the frozen outputs
			@(posedge clk);
			held = range_type;
			range_type <= 12'($urandom);
			clk_en <= 1'b0;
			repeat (2) @(negedge clk);
			chk_all(held);
			@(posedge clk);
			clk_en <= 1'b1;
			repeat (2) @(negedge clk);
			chk("no load", 17'h0, {16'h0000, dac_load});
			chk_all(range_type);
			$display("test %0d done", t);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
